/* core/scr_sysctl.sv */
// The implementer's own choices: register access over AXI4-Lite and the address map.
`timescale 1ns/1ps
// What this block does
// - Pin group bit moves PWM0, INT, tone pins
// - Tone clock from timer0 or timer1
// - Split bit picks 6+2 or 7+1 PWM
// - PWM0/PWM1 drive pins only when enabled
// - Tone enable puts tone on its pin
// - Crystal low-power bit picks crystal mode
// - Clock mode bit selects crystal, stops fast
// - Any enabled PWM forces system timer clock
// - Edge field: off, rise, fall, both
// - Time-base period 2^10 to 2^13 ticks
// - Watchdog code 1010 requests disable
// - Watchdog option on overrides the code
// - Converter enable bit drives converter
// - PWM2/PWM3 drive pins only when enabled
// - Keep-alive bit keeps crystal after halt
// - Unused third-register bits read zero
// - Masked port A falling edge wakes
// - Internal RC never becomes system clock
// - Crystal low-power bit cleared at reset
// - Halt enters idle or sleep, fast stops
module scr_sysctl #(
    parameter int PORT_W = 8
) (
    input  wire logic                 aclk,
    input  wire logic                 aresetn,
    input  wire scr_pkg::scr_axi_req_s req,
    output      scr_pkg::scr_axi_rsp_s rsp,
    input  wire logic [PORT_W-1:0]    pa_in,
    input  wire logic [PORT_W-1:0]    pb_in,
    input  wire logic [3:0]           pwm_in,
    input  wire logic                 tone_gen_in,
    input  wire logic                 timer0_tick,
    input  wire logic                 timer1_tick,
    input  wire logic                 tp_tick,
    input  wire logic                 halt_req,
    input  wire logic                 wdt_option,
    output      logic [PORT_W-1:0]    pa_fn_sel,
    output      logic [PORT_W-1:0]    pa_fn_out,
    output      logic [PORT_W-1:0]    pb_fn_sel,
    output      logic [PORT_W-1:0]    pb_fn_out,
    output      logic [3:0]           pwm_pin_sel,
    output      logic [3:0]           pwm_pin_out,
    output      logic                 tone_clk_tick,
    output      logic                 tone_src_timer1,
    output      logic                 pwm_split_7p1,
    output      logic                 tp_from_sys,
    output      logic                 timebase_tick,
    output      logic                 ext_int_pulse,
    output      logic                 wdt_enable,
    output      logic                 converter_enable,
    output      logic                 crystal_low_power,
    output      logic                 sys_clk_lxt,
    output      logic                 hs_osc_run,
    output      logic                 lxt_run,
    output      scr_pkg::scr_mode_e   power_mode
);

    // ****************************************
    // Parameter check
    // ****************************************
    if (PORT_W < 6 || PORT_W > 8) begin : g_bad_width
        $error("PORT_W must lie between 6 and 8");
    end

    localparam int TW = scr_pkg::TB_CNT_W;

    typedef struct packed {
        logic [7:0]         ctrl_a;
        logic [7:0]         ctrl_b;
        logic [7:0]         ctrl_c;
        logic [7:0]         wake_sel;
        scr_pkg::scr_mode_e mode;
        logic               aw_got;
        logic [7:0]         awaddr;
        logic               w_got;
        logic [7:0]         wdata;
        logic               wlane;
        logic               bvalid;
        logic [1:0]         bresp;
        logic               rvalid;
        logic [1:0]         rresp;
        logic [7:0]         rdata;
        logic               int_prev;
        logic [PORT_W-1:0]  wake_prev;
        logic [TW-1:0]      tb_cnt;
        logic               tb_tick;
        logic               int_pulse;
        logic               tone_tick;
        logic [PORT_W-1:0]  pa_sel;
        logic [PORT_W-1:0]  pa_out;
        logic [PORT_W-1:0]  pb_sel;
        logic [PORT_W-1:0]  pb_out;
        logic [3:0]         pwm_sel;
        logic [3:0]         pwm_out;
    } scr_state_s;

    scr_state_s q;
    scr_state_s n;

    // ****************************************
    // Helpers
    // ****************************************
    // Unaligned or unlisted addresses map to none
    function automatic logic [2:0] reg_idx(input logic [7:0] a);
        case (a)
            scr_pkg::ADDR_CTRL_A: reg_idx = scr_pkg::IDX_A;
            scr_pkg::ADDR_CTRL_B: reg_idx = scr_pkg::IDX_B;
            scr_pkg::ADDR_CTRL_C: reg_idx = scr_pkg::IDX_C;
            scr_pkg::ADDR_WAKE:   reg_idx = scr_pkg::IDX_W;
            scr_pkg::ADDR_STATUS: reg_idx = scr_pkg::IDX_S;
            default:              reg_idx = scr_pkg::IDX_NONE;
        endcase
    endfunction : reg_idx

    // Low bits that must be all ones for a time-base tick
    function automatic logic [TW-1:0] tb_mask(input logic [1:0] sel);
        tb_mask = TW'((1 << (scr_pkg::TB_EXP_BASE + int'(sel))) - 1);
    endfunction : tb_mask

    // ****************************************
    // Decoded control
    // ****************************************
    logic       grp;
    logic [3:0] pwm_en;
    logic       int_src;
    logic [1:0] edge_sel;
    logic [PORT_W-1:0] wake_fall;

    assign grp = q.ctrl_a[scr_pkg::A_PIN_GRP];
    assign pwm_en = {q.ctrl_c[scr_pkg::C_PWM3], q.ctrl_c[scr_pkg::C_PWM2],
                     q.ctrl_a[scr_pkg::A_PWM1], q.ctrl_a[scr_pkg::A_PWM0]};
    assign int_src = grp ? pb_in[scr_pkg::PB_INT] : pa_in[scr_pkg::PA_INT];
    assign edge_sel = q.ctrl_b[scr_pkg::B_EDGE_LSB +: 2];
    // falling edge on selected port A pins
    assign wake_fall = q.wake_prev & ~pa_in & q.wake_sel[PORT_W-1:0];

    // ****************************************
    // Next state
    // ****************************************
    always_comb begin
        logic [2:0] widx;
        logic [2:0] ridx;
        widx = reg_idx(q.awaddr);
        ridx = reg_idx(req.araddr);
        n = q;
        // Write address and data are taken in either order
        if (req.awvalid && rsp.awready) begin
            n.aw_got = 1'b1;
            n.awaddr = req.awaddr;
        end
        if (req.wvalid && rsp.wready) begin
            n.w_got = 1'b1;
            n.wdata = req.wdata[7:0];
            n.wlane = req.wstrb[0];
        end
        if (q.bvalid && req.bready) begin
            n.bvalid = 1'b0;
        end
        // Commit once both halves are held; only byte lane 0 counts
        if (q.aw_got && q.w_got && !q.bvalid) begin
            n.aw_got = 1'b0;
            n.w_got = 1'b0;
            n.bvalid = 1'b1;
            n.bresp = (widx == scr_pkg::IDX_NONE) ? scr_pkg::RESP_SLVERR
                                                  : scr_pkg::RESP_OKAY;
            if (q.wlane) begin
                case (widx)
                    scr_pkg::IDX_A: n.ctrl_a = q.wdata;
                    scr_pkg::IDX_B: n.ctrl_b = q.wdata;
                    scr_pkg::IDX_C: n.ctrl_c = q.wdata & scr_pkg::CTRL_C_MASK;
                    scr_pkg::IDX_W: n.wake_sel = q.wdata;
                    default: ;
                endcase
            end
        end
        // Read channel, one outstanding read
        if (q.rvalid && req.rready) begin
            n.rvalid = 1'b0;
        end
        if (req.arvalid && rsp.arready) begin
            n.rvalid = 1'b1;
            n.rresp = scr_pkg::RESP_OKAY;
            case (ridx)
                scr_pkg::IDX_A: n.rdata = q.ctrl_a;
                scr_pkg::IDX_B: n.rdata = q.ctrl_b;
                scr_pkg::IDX_C: n.rdata = q.ctrl_c & scr_pkg::CTRL_C_MASK;
                scr_pkg::IDX_W: n.rdata = q.wake_sel;
                scr_pkg::IDX_S: begin
                    n.rdata = 8'h00;
                    n.rdata[1:0] = q.mode;
                    n.rdata[scr_pkg::S_WDT] = wdt_enable;
                end
                default: begin
                    n.rdata = 8'h00;
                    n.rresp = scr_pkg::RESP_SLVERR;
                end
            endcase
        end

        n.wake_prev = pa_in;
        unique case (q.mode)
            scr_pkg::SCR_NORMAL, scr_pkg::SCR_SLOW: begin
                if (halt_req) begin
                    n.mode = q.ctrl_c[scr_pkg::C_KEEP] ? scr_pkg::SCR_IDLE
                                                       : scr_pkg::SCR_SLEEP;
                end else begin
                    // clock mode picks slow crystal running
                    n.mode = q.ctrl_a[scr_pkg::A_CLK_MODE] ? scr_pkg::SCR_SLOW
                                                           : scr_pkg::SCR_NORMAL;
                end
            end
            scr_pkg::SCR_IDLE, scr_pkg::SCR_SLEEP: begin
                if (|wake_fall) begin
                    n.mode = q.ctrl_a[scr_pkg::A_CLK_MODE] ? scr_pkg::SCR_SLOW
                                                           : scr_pkg::SCR_NORMAL;
                end
            end
        endcase

        // edge type decode; a group switch may look like an edge
        n.int_prev = int_src;
        unique case (edge_sel)
            scr_pkg::EDGE_OFF:  n.int_pulse = 1'b0;
            scr_pkg::EDGE_RISE: n.int_pulse = int_src & ~q.int_prev;
            scr_pkg::EDGE_FALL: n.int_pulse = ~int_src & q.int_prev;
            scr_pkg::EDGE_BOTH: n.int_pulse = int_src ^ q.int_prev;
        endcase

        // free-running count, tick every 2^(10+sel) timer ticks
        n.tb_cnt = q.tb_cnt + {{(TW-1){1'b0}}, tp_tick};
        n.tb_tick = tp_tick &&
            ((q.tb_cnt & tb_mask(q.ctrl_b[scr_pkg::B_TB_LSB +: 2]))
             == tb_mask(q.ctrl_b[scr_pkg::B_TB_LSB +: 2]));

        n.tone_tick = q.ctrl_a[scr_pkg::A_TONE_SRC] ? timer1_tick
                                                    : timer0_tick;

        // PWM pins owned only when enabled
        n.pwm_sel = pwm_en;
        n.pwm_out = pwm_in & pwm_en;

        n.pa_sel = '0;
        n.pa_out = '0;
        n.pb_sel = '0;
        n.pb_out = '0;
        if (!grp) begin
            n.pa_sel[scr_pkg::PA_PWM0] = pwm_en[0];
            n.pa_out[scr_pkg::PA_PWM0] = pwm_in[0] & pwm_en[0];
            // tone on its pin only when enabled
            n.pa_sel[scr_pkg::PA_TONE] = q.ctrl_a[scr_pkg::A_TONE_EN];
            n.pa_out[scr_pkg::PA_TONE] = tone_gen_in &
                                         q.ctrl_a[scr_pkg::A_TONE_EN];
        end else begin
            n.pb_sel[scr_pkg::PB_PWM0] = pwm_en[0];
            n.pb_out[scr_pkg::PB_PWM0] = pwm_in[0] & pwm_en[0];
            // tone on its pin only when enabled
            n.pb_sel[scr_pkg::PB_TONE] = q.ctrl_a[scr_pkg::A_TONE_EN];
            n.pb_out[scr_pkg::PB_TONE] = tone_gen_in &
                                         q.ctrl_a[scr_pkg::A_TONE_EN];
        end
    end

    // ****************************************
    // State register
    // ****************************************
    // reset values, low-power crystal bit cleared
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            q <= '0;
            q.ctrl_a <= scr_pkg::RST_CTRL_A;
            q.ctrl_b <= scr_pkg::RST_CTRL_B;
            q.ctrl_c <= scr_pkg::RST_CTRL_C;
            q.wake_sel <= scr_pkg::RST_WAKE;
            q.mode <= scr_pkg::SCR_NORMAL;
        end else begin
            q <= n;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    // Ready only while the matching slot is free
    assign rsp.awready = !q.aw_got && !q.bvalid;
    assign rsp.wready  = !q.w_got && !q.bvalid;
    assign rsp.bvalid  = q.bvalid;
    assign rsp.bresp   = q.bresp;
    assign rsp.arready = !q.rvalid;
    assign rsp.rvalid  = q.rvalid;
    assign rsp.rdata   = {24'h000000, q.rdata};
    assign rsp.rresp   = q.rresp;

    assign pa_fn_sel       = q.pa_sel;
    assign pa_fn_out       = q.pa_out;
    assign pb_fn_sel       = q.pb_sel;
    assign pb_fn_out       = q.pb_out;
    assign pwm_pin_sel     = q.pwm_sel;
    assign pwm_pin_out     = q.pwm_out;
    assign tone_clk_tick   = q.tone_tick;
    assign timebase_tick   = q.tb_tick;
    assign ext_int_pulse   = q.int_pulse;
    assign power_mode      = q.mode;
    assign tone_src_timer1 = q.ctrl_a[scr_pkg::A_TONE_SRC];
    assign pwm_split_7p1   = q.ctrl_a[scr_pkg::A_SPLIT];
    // any PWM forces system clock as timer clock
    assign tp_from_sys     = |pwm_en;
    // option wins; only code 1010 disables
    assign wdt_enable = wdt_option ||
        (q.ctrl_b[scr_pkg::B_WDT_LSB +: 4] != scr_pkg::WDT_OFF);
    assign converter_enable  = q.ctrl_c[scr_pkg::C_CONV];
    assign crystal_low_power = q.ctrl_a[scr_pkg::A_XTAL_LP];
    // system clock is fast oscillator or crystal only
    assign sys_clk_lxt = q.ctrl_a[scr_pkg::A_CLK_MODE];
    // fast oscillator runs only in normal mode
    assign hs_osc_run  = (q.mode == scr_pkg::SCR_NORMAL);
    assign lxt_run     = (q.mode != scr_pkg::SCR_SLEEP);

    // ****************************************
    // Checks
    // ****************************************
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    a_reset_values: assert property (
        $rose(aresetn) |-> q.ctrl_a == scr_pkg::RST_CTRL_A &&
        q.ctrl_b == scr_pkg::RST_CTRL_B && q.ctrl_c == scr_pkg::RST_CTRL_C)
        else $error("register reset value wrong");
    a_ctrl_c_zero: assert property (
        req.arvalid && rsp.arready && req.araddr == scr_pkg::ADDR_CTRL_C
        |=> rsp.rvalid && rsp.rdata[6] == 1'b0 && rsp.rdata[3:1] == 3'h0)
        else $error("reserved bits read nonzero");
    a_wdt_code: assert property (
        !wdt_option && rsp.rvalid && $past(req.arvalid && rsp.arready &&
        req.araddr == scr_pkg::ADDR_CTRL_B) && rsp.rdata[3:0] == 4'ha
        |-> !wdt_enable)
        else $error("watchdog not disabled by code");
    // timer clock forced
    // Pin ownership lags the enable bits by one registered cycle
    a_pwm_force: assert property (
        |pwm_pin_sel |-> $past(tp_from_sys))
        else $error("pwm without system timer clock");
    a_halt_idle: assert property (
        halt_req && power_mode == scr_pkg::SCR_NORMAL && q.ctrl_c[0]
        |=> power_mode == scr_pkg::SCR_IDLE && !hs_osc_run && lxt_run)
        else $error("halt did not enter idle");
    a_wake_fall: assert property (
        power_mode == scr_pkg::SCR_SLEEP && |wake_fall
        |=> power_mode inside {scr_pkg::SCR_NORMAL, scr_pkg::SCR_SLOW})
        else $error("falling edge did not wake");
    a_int_rise: assert property (
        edge_sel == 2'h1 && $stable(grp) && $rose(int_src) |=> ext_int_pulse)
        else $error("rising edge lost");
    a_int_off: assert property (
        $past(edge_sel) == 2'h0 |-> !ext_int_pulse)
        else $error("interrupt while disabled");
    a_pin_route: assert property (
        pa_fn_sel[4] |-> $past(!grp) && $past(pwm_en[0]))
        else $error("pwm0 on wrong port");
    // Response holds until taken
    a_resp_hold: assert property (
        rsp.bvalid && !req.bready |=> rsp.bvalid)
        else $error("write response dropped");

    c_write: cover property (rsp.bvalid && req.bready);
    c_read: cover property (rsp.rvalid && req.rready);
    c_idle: cover property (power_mode == scr_pkg::SCR_IDLE);
    c_wake: cover property (power_mode == scr_pkg::SCR_SLEEP ##1
                            power_mode == scr_pkg::SCR_NORMAL);

endmodule : scr_sysctl

/* core/scr_pkg.sv */
package scr_pkg;

    // ****************************************
    // Register map
    // ****************************************
    localparam int         AXI_AW      = 8;
    localparam logic [7:0] ADDR_CTRL_A = 8'h00;
    localparam logic [7:0] ADDR_CTRL_B = 8'h04;
    localparam logic [7:0] ADDR_CTRL_C = 8'h08;
    localparam logic [7:0] ADDR_WAKE   = 8'h0c;
    localparam logic [7:0] ADDR_STATUS = 8'h10;

    localparam logic [7:0] RST_CTRL_A  = 8'h00;
    localparam logic [7:0] RST_CTRL_B  = 8'h8a;
    localparam logic [7:0] RST_CTRL_C  = 8'h01;
    localparam logic [7:0] RST_WAKE    = 8'h00;
    localparam logic [7:0] CTRL_C_MASK = 8'hb1;

    // Register indices after decode
    localparam logic [2:0] IDX_A    = 3'h0;
    localparam logic [2:0] IDX_B    = 3'h1;
    localparam logic [2:0] IDX_C    = 3'h2;
    localparam logic [2:0] IDX_W    = 3'h3;
    localparam logic [2:0] IDX_S    = 3'h4;
    localparam logic [2:0] IDX_NONE = 3'h7;

    // ****************************************
    // Field positions
    // ****************************************
    localparam int A_PIN_GRP  = 7;
    localparam int A_TONE_SRC = 6;
    localparam int A_SPLIT    = 5;
    localparam int A_PWM1     = 4;
    localparam int A_PWM0     = 3;
    localparam int A_TONE_EN  = 2;
    localparam int A_XTAL_LP  = 1;
    localparam int A_CLK_MODE = 0;
    localparam int B_EDGE_LSB = 6;
    localparam int B_TB_LSB   = 4;
    localparam int B_WDT_LSB  = 0;
    localparam int C_CONV     = 7;
    localparam int C_PWM3     = 5;
    localparam int C_PWM2     = 4;
    localparam int C_KEEP     = 0;
    localparam int S_WDT      = 2;

    // Shared pin positions on port A and port B
    localparam int PA_PWM0 = 4;
    localparam int PA_INT  = 3;
    localparam int PA_TONE = 1;
    localparam int PB_PWM0 = 5;
    localparam int PB_INT  = 4;
    localparam int PB_TONE = 3;

    // ****************************************
    // Codes
    // ****************************************
    localparam logic [1:0] EDGE_OFF    = 2'h0;
    localparam logic [1:0] EDGE_RISE   = 2'h1;
    localparam logic [1:0] EDGE_FALL   = 2'h2;
    localparam logic [1:0] EDGE_BOTH   = 2'h3;
    localparam logic [3:0] WDT_OFF     = 4'ha;
    localparam int         TB_EXP_BASE = 10;
    localparam int         TB_CNT_W    = 13;
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {
        SCR_NORMAL,
        SCR_SLOW,
        SCR_IDLE,
        SCR_SLEEP
    } scr_mode_e;

    typedef struct packed {
        logic              awvalid;
        logic [AXI_AW-1:0] awaddr;
        logic              wvalid;
        logic [31:0]       wdata;
        logic [3:0]        wstrb;
        logic              bready;
        logic              arvalid;
        logic [AXI_AW-1:0] araddr;
        logic              rready;
    } scr_axi_req_s;

    typedef struct packed {
        logic        awready;
        logic        wready;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
    } scr_axi_rsp_s;

endpackage : scr_pkg

/* dv/test_system_control_registers.sv */
`timescale 1ns/1ps
module test_system_control_registers;
    logic                  aclk;
    logic                  aresetn;
    scr_pkg::scr_axi_req_s req;
    scr_pkg::scr_axi_rsp_s rsp;
    logic [7:0]            pa_in;
    logic [7:0]            pb_in;
    logic [3:0]            pwm_in;
    logic                  tone_gen_in;
    logic                  timer0_tick;
    logic                  timer1_tick;
    logic                  tp_tick;
    logic [7:0]            pb_fn_out;
    logic                  tone_clk_tick;
    logic                  timebase_tick;
    logic                  halt_req;
    logic                  wdt_option;
    logic [7:0]            pa_fn_sel;
    logic [7:0]            pa_fn_out;
    logic [7:0]            pb_fn_sel;
    logic [3:0]            pwm_pin_sel;
    logic [3:0]            pwm_pin_out;
    logic                  tone_src_timer1;
    logic                  pwm_split_7p1;
    logic                  tp_from_sys;
    logic                  ext_int_pulse;
    logic                  wdt_enable;
    logic                  converter_enable;
    logic                  crystal_low_power;
    logic                  sys_clk_lxt;
    logic                  hs_osc_run;
    logic                  lxt_run;
    scr_pkg::scr_mode_e    power_mode;
    int                    error_cnt = 0;
    int                    checks = 0;
    int                    cyc = 0;
    int                    pulses = 0;

    // Every design input is driven by the bench
    scr_sysctl dut (
        .aclk, .aresetn, .req, .rsp, .pa_in, .pb_in, .pwm_in,
        .tone_gen_in, .timer0_tick, .timer1_tick,
        .tp_tick, .halt_req, .wdt_option, .pa_fn_sel, .pa_fn_out,
        .pb_fn_sel, .pb_fn_out, .pwm_pin_sel, .pwm_pin_out,
        .tone_clk_tick, .tone_src_timer1, .pwm_split_7p1, .tp_from_sys,
        .timebase_tick, .ext_int_pulse, .wdt_enable, .converter_enable,
        .crystal_low_power, .sys_clk_lxt, .hs_osc_run, .lxt_run, .power_mode
    );

    // Clock at 50 MHz
    initial begin
        aclk = 1'b0;
        forever #10 aclk = ~aclk;
    end

    // Hang guard and pulse counter
    always @(posedge aclk) begin
        cyc++;
        if (ext_int_pulse === 1'b1) pulses++;
        if (cyc == 20000) begin
            error_cnt++;
            end_of_test();
        end
    end

    // ****************************************
    // Shared tasks
    // ****************************************
    task automatic end_of_test();
        $display("errors=%0d checks=%0d", error_cnt, checks);
        if (error_cnt == 0 && checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : end_of_test

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic tick(input int n);
        repeat (n) @(posedge aclk);
    endtask : tick

    // Leading edge keeps two bus calls from driving in one time step
    task automatic wr(input logic [7:0] a, input logic [7:0] d,
                      input logic [1:0] er);
        int n;
        n = 0;
        @(posedge aclk);
        req.awvalid <= 1'b1;
        req.awaddr  <= a;
        req.wvalid  <= 1'b1;
        req.wdata   <= {24'h0, d};
        req.wstrb   <= 4'hf;
        req.bready  <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
            if (req.awvalid && rsp.awready) req.awvalid <= 1'b0;
            if (req.wvalid && rsp.wready) req.wvalid <= 1'b0;
        end while (rsp.bvalid !== 1'b1 && n < 50);
        req.bready <= 1'b0;
        chk(rsp.bresp, er);
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] ed,
                      input logic [1:0] er);
        int n;
        n = 0;
        @(posedge aclk);
        req.arvalid <= 1'b1;
        req.araddr  <= a;
        req.rready  <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
            if (req.arvalid && rsp.arready) req.arvalid <= 1'b0;
        end while (rsp.rvalid !== 1'b1 && n < 50);
        req.rready <= 1'b0;
        chk(rsp.rdata, ed);
        chk(rsp.rresp, er);
    endtask : rd

    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_regs();
        rd(scr_pkg::ADDR_CTRL_A, 32'h00, scr_pkg::RESP_OKAY);
        rd(scr_pkg::ADDR_CTRL_B, 32'h8a, scr_pkg::RESP_OKAY);
        rd(scr_pkg::ADDR_CTRL_C, 32'h01, scr_pkg::RESP_OKAY);
        chk({hs_osc_run, lxt_run, wdt_enable, crystal_low_power}, 4'hc);
        wr(scr_pkg::ADDR_CTRL_C, 8'hff, scr_pkg::RESP_OKAY);
        rd(scr_pkg::ADDR_CTRL_C, 32'hb1, scr_pkg::RESP_OKAY);
        wr(8'h14, 8'h55, scr_pkg::RESP_SLVERR);
        rd(8'h14, 32'h0, scr_pkg::RESP_SLVERR);
        wr(scr_pkg::ADDR_CTRL_A, 8'h62, scr_pkg::RESP_OKAY);
        rd(scr_pkg::ADDR_CTRL_A, 32'h62, scr_pkg::RESP_OKAY);
        tick(2);
        chk({tone_src_timer1, pwm_split_7p1, crystal_low_power}, 3'h7);
        chk(tone_clk_tick, 1'b1);
        chk({converter_enable, tp_from_sys}, 2'h3);
        wr(scr_pkg::ADDR_CTRL_C, 8'h01, scr_pkg::RESP_OKAY);
        wr(scr_pkg::ADDR_CTRL_A, 8'h00, scr_pkg::RESP_OKAY);
        tick(2);
        chk({tone_src_timer1, pwm_split_7p1, converter_enable}, 3'h0);
        chk(tone_clk_tick, 1'b0);
    endtask : t_regs

    // Pin ownership moves between ports with the group bit
    task automatic t_pins();
        for (int g = 0; g < 2; g++) begin
            wr(scr_pkg::ADDR_CTRL_A, {g[0], 7'h0c}, scr_pkg::RESP_OKAY);
            tick(2);
            chk(pa_fn_sel, g ? 8'h00 : 8'h12);
            chk(pb_fn_sel, g ? 8'h28 : 8'h00);
            chk({pa_fn_out, pb_fn_out}, g ? 16'h0028 : 16'h1200);
            chk({tp_from_sys, pwm_pin_sel, pwm_pin_out}, 9'h111);
        end
        wr(scr_pkg::ADDR_CTRL_A, 8'h10, scr_pkg::RESP_OKAY);
        wr(scr_pkg::ADDR_CTRL_C, 8'h31, scr_pkg::RESP_OKAY);
        tick(2);
        chk({tp_from_sys, pwm_pin_sel, pwm_pin_out}, 9'h1ee);
        wr(scr_pkg::ADDR_CTRL_A, 8'h00, scr_pkg::RESP_OKAY);
        wr(scr_pkg::ADDR_CTRL_C, 8'h01, scr_pkg::RESP_OKAY);
        tick(2);
        chk({tp_from_sys, pwm_pin_sel, pa_fn_sel}, 13'h0);
    endtask : t_pins

    task automatic t_wdt();
        for (int i = 0; i < 4; i++) begin
            wdt_option <= i[1];
            wr(scr_pkg::ADDR_CTRL_B, i[0] ? 8'h85 : 8'h8a, scr_pkg::RESP_OKAY);
            tick(1);
            chk(wdt_enable, i[1] | i[0]);
        end
        wdt_option <= 1'b0;
    endtask : t_wdt

    // One low pulse on the interrupt pin: off, rise, fall, both
    task automatic t_edge();
        for (int c = 0; c < 4; c++) begin
            wr(scr_pkg::ADDR_CTRL_B, {c[1:0], 6'h05}, scr_pkg::RESP_OKAY);
            tick(3);
            pulses = 0;
            pa_in[3] <= 1'b0;
            tick(3);
            pa_in[3] <= 1'b1;
            tick(3);
            chk(pulses, c[0] + c[1]);
        end
        // Group 1 moves the interrupt pin to port B, both edges
        wr(scr_pkg::ADDR_CTRL_A, 8'h80, scr_pkg::RESP_OKAY);
        tick(3);
        pulses = 0;
        pb_in[4] <= 1'b0;
        tick(3);
        pb_in[4] <= 1'b1;
        tick(3);
        chk(pulses, 2);
    endtask : t_edge

    // Time-base pulses come 2^10, then 2^11 timer ticks apart
    task automatic t_tbase();
        int gap;
        for (int s = 0; s < 2; s++) begin
            wr(scr_pkg::ADDR_CTRL_B, {2'h0, s[1:0], 4'h5}, scr_pkg::RESP_OKAY);
            tp_tick <= 1'b1;
            do begin
                tick(1);
            end while (timebase_tick !== 1'b1);
            gap = 0;
            do begin
                tick(1);
                gap++;
            end while (timebase_tick !== 1'b1);
            chk(gap, 32'h400 << s);
        end
        tp_tick <= 1'b0;
    endtask : t_tbase

    task automatic t_power();
        wr(scr_pkg::ADDR_CTRL_A, 8'h01, scr_pkg::RESP_OKAY);
        tick(2);
        chk({power_mode, sys_clk_lxt, hs_osc_run}, 4'h6);
        wr(scr_pkg::ADDR_CTRL_A, 8'h00, scr_pkg::RESP_OKAY);
        wr(scr_pkg::ADDR_WAKE, 8'h01, scr_pkg::RESP_OKAY);
        for (int k = 1; k >= 0; k--) begin
            wr(scr_pkg::ADDR_CTRL_C, {7'h0, k[0]}, scr_pkg::RESP_OKAY);
            halt_req <= 1'b1;
            tick(1);
            halt_req <= 1'b0;
            tick(3);
            chk(power_mode, k ? scr_pkg::SCR_IDLE : scr_pkg::SCR_SLEEP);
            chk({hs_osc_run, lxt_run}, {1'b0, k[0]});
            pa_in[0] <= 1'b0;
            tick(3);
            chk({power_mode, hs_osc_run}, 3'h1);
            pa_in[0] <= 1'b1;
        end
    endtask : t_power

    // Main sequence
    initial begin
        aresetn    = 1'b0;
        req        = '0;
        pa_in      = 8'hff;
        pb_in      = 8'hff;
        pwm_in     = 4'hf;
        tone_gen_in = 1'b1;
        timer0_tick = 1'b0;
        timer1_tick = 1'b1;
        tp_tick    = 1'b0;
        halt_req   = 1'b0;
        wdt_option = 1'b0;
        tick(16);
        aresetn <= 1'b1;
        t_regs();
        t_pins();
        t_wdt();
        t_edge();
        t_power();
        t_tbase();
        tick(2);
        end_of_test();
    end
endmodule : test_system_control_registers
